// *** core/bootstrap_init_power_up_seq.sv ***
// bootstrap init and power-up sequencer top
//
// Functional notes
// - digital outputs ready 100 us after por
// - reference clock ignored until outputs ready
// - core reset merges por, pin, serial request
// - serial module held inactive during core reset
// - low bootstrap current limit per driver in init
// - init threshold 0.5 V then 1.0 V
// - all low-side bias on while any init
// - high-side bias off during its init
// - strap 1 forces internal regulator during init
// - one 36 ms init timer after supply ok
// - timer expiry sets one-volt indicator bits
// - five conditions end a driver's init
// - charging starts after reset and supply ok
// - linked low-side on ends init, high limit
// - undervoltage keeps all mosfets and diodes off
// - low-side switchable after 16 us above threshold
// - undervoltage re-entry drops low-side, re-delays
`timescale 1ns/1ps
`include "bootstrap_seq_cfg.svh"

module bootstrap_init_power_up_seq #(
	parameter int DIGIO_READY_CYCLES = `DIGIO_READY_CYCLES,
	parameter int INIT_TIMER_CYCLES  = `INIT_TIMER_CYCLES
) (
	// clock and reset
	input  wire logic                         clock,
	input  wire logic                         resetn,
	// reset sources, straps and reference clock
	input  wire logic                         power_on_reset_n,
	input  wire logic                         external_reset_pin_n,
	input  wire logic                         serial_port_reset_request_n,
	input  wire logic                         debug_strap_pin,
	input  wire logic                         ref_clock_pin,
	// supply and comparators
	input  wire logic                         predriver_supply_undervoltage,
	input  wire bootstrap_seq_pkg::hs_vec_t   bs_ready,
	input  wire bootstrap_seq_pkg::hs_vec_t   clamp_active,
	input  wire bootstrap_seq_pkg::hs_vec_t   source_below_threshold,
	// driver requests
	input  wire bootstrap_seq_pkg::hs_vec_t   hs_on_request,
	input  wire bootstrap_seq_pkg::ls_vec_t   ls_on_request,
	// register port
	input  wire logic                         reg_write,
	input  wire logic [`ADDR_W-1:0]           reg_addr,
	input  wire bootstrap_seq_pkg::reg_word_t reg_wdata,
	output bootstrap_seq_pkg::reg_word_t      reg_rdata,
	// sequencing status
	output logic                              combined_reset_n,
	output logic                              serial_enable,
	output logic                              digital_outputs_ready,
	output logic                              ref_clock_qualified,
	output bootstrap_seq_pkg::hs_vec_t        init_active,
	// init overrides
	output bootstrap_seq_pkg::hs_vec_t        bootstrap_low_current_limit,
	output bootstrap_seq_pkg::thr_vec_t       source_threshold,
	output bootstrap_seq_pkg::hs_vec_t        one_volt_threshold_indicator,
	output bootstrap_seq_pkg::ls_vec_t        low_side_bias_enable,
	output bootstrap_seq_pkg::hs_vec_t        high_side_bias_enable,
	output logic                              vccp_external_enable,
	// gate drive
	output bootstrap_seq_pkg::hs_vec_t        hs_gate,
	output bootstrap_seq_pkg::ls_vec_t        ls_gate,
	output logic                              bootstrap_diode_enable
);

	localparam int SYNC_W = 5 + 3 * `NUM_HS;

	logic                         rst_meta;
	logic                         rst_n;
	logic [SYNC_W-1:0]            pin_meta;
	logic [SYNC_W-1:0]            pin_sync;
	logic                         por_s;
	logic                         ext_s;
	logic                         dbg_s;
	logic                         uv_s;
	logic                         ref_s;
	bootstrap_seq_pkg::hs_vec_t   bs_ready_s;
	bootstrap_seq_pkg::hs_vec_t   clamp_s;
	bootstrap_seq_pkg::hs_vec_t   below_s;
	logic                         core_rst_n;
	logic                         next_core_rst_n;
	logic                         strap_dbg;
	logic [`CNT_W-1:0]            ready_cnt;
	logic [`CNT_W-1:0]            uv_cnt;
	logic                         uv_ok;
	logic [`CNT_W-1:0]            init_cnt;
	logic                         init_started;
	logic                         init_expired;
	bootstrap_seq_pkg::hs_vec_t   init_flag;
	bootstrap_seq_pkg::hs_vec_t   init_exit;
	bootstrap_seq_pkg::hs_vec_t   one_volt;
	bootstrap_seq_pkg::reg_word_t thr_reg;
	bootstrap_seq_pkg::reg_word_t high_side_bias_enable_reg;
	bootstrap_seq_pkg::reg_word_t low_side_bias_enable_reg;
	bootstrap_seq_pkg::reg_word_t bs_reg;
	bootstrap_seq_pkg::ls_vec_t   link_reg [`NUM_HS];
	logic                         any_init;
	logic                         wr_ok;
	logic                         wr_thr;
	logic                         wr_high_side_bias_enable;
	logic                         wr_low_side_bias_enable;
	logic                         wr_bs;
	bootstrap_seq_pkg::hs_vec_t   wr_link;
	bootstrap_seq_pkg::hs_vec_t   link_dis;
	bootstrap_seq_pkg::reg_word_t next_rdata;
	bootstrap_seq_pkg::thr_vec_t  next_thr;
	bootstrap_seq_pkg::hs_vec_t   next_hs_gate;
	bootstrap_seq_pkg::ls_vec_t   next_ls_gate;
	logic                         next_vccp_ext;

	// reset release through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pins and analog comparators are asynchronous to the system clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {power_on_reset_n, external_reset_pin_n, debug_strap_pin,
				predriver_supply_undervoltage, ref_clock_pin,
				bs_ready, clamp_active, source_below_threshold};
			pin_sync <= pin_meta;
		end
	end

	assign por_s      = pin_sync[SYNC_W-1];
	assign ext_s      = pin_sync[SYNC_W-2];
	assign dbg_s      = pin_sync[SYNC_W-3];
	assign uv_s       = pin_sync[SYNC_W-4];
	assign ref_s      = pin_sync[SYNC_W-5];
	assign bs_ready_s = pin_sync[3*`NUM_HS-1 -: `NUM_HS];
	assign clamp_s    = pin_sync[2*`NUM_HS-1 -: `NUM_HS];
	assign below_s    = pin_sync[`NUM_HS-1:0];

	// any single source holds the core in reset
	assign next_core_rst_n = por_s & ext_s & serial_port_reset_request_n;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_rst_n <= 1'b0;
			strap_dbg  <= 1'b0;
		end else begin
			core_rst_n <= next_core_rst_n;
			// last value seen during reset is kept after release
			if (!core_rst_n)
				strap_dbg <= dbg_s;
		end
	end

	// output readiness counts from power-on release only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ready_cnt             <= '0;
			digital_outputs_ready <= 1'b0;
		end else if (!por_s) begin
			ready_cnt             <= '0;
			digital_outputs_ready <= 1'b0;
		end else if (ready_cnt == `CNT_W'(DIGIO_READY_CYCLES - 1)) begin
			digital_outputs_ready <= 1'b1;
		end else begin
			ready_cnt <= ready_cnt + `CNT_W'(1);
		end
	end

	// supply-good delay restarts on every undervoltage dip
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			uv_cnt <= '0;
			uv_ok  <= 1'b0;
		end else if (uv_s) begin
			uv_cnt <= '0;
			uv_ok  <= 1'b0;
		end else if (uv_cnt == `CNT_W'(`UV_DELAY_CYCLES - 1)) begin
			uv_ok <= 1'b1;
		end else begin
			uv_cnt <= uv_cnt + `CNT_W'(1);
		end
	end

	// one global timer; a later dip does not restart it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt     <= '0;
			init_started <= 1'b0;
			init_expired <= 1'b0;
		end else if (!core_rst_n) begin
			init_cnt     <= '0;
			init_started <= 1'b0;
			init_expired <= 1'b0;
		end else if (!init_started) begin
			init_started <= !uv_s;
		end else if (init_cnt == `CNT_W'(INIT_TIMER_CYCLES - 1)) begin
			init_expired <= 1'b1;
		end else if (!init_expired) begin
			init_cnt <= init_cnt + `CNT_W'(1);
		end
	end

	// register write decode, ignored while the serial side is held off
	assign wr_ok = reg_write & core_rst_n;

	always_comb begin
		wr_thr     = 1'b0;
		wr_high_side_bias_enable = 1'b0;
		wr_low_side_bias_enable = 1'b0;
		wr_bs      = 1'b0;
		if (!wr_ok)
			wr_thr = 1'b0;
		else if (reg_addr == `ADDR_SRC_THR_PART2)
			wr_thr = 1'b1;
		else if (reg_addr == `ADDR_HIGH_SIDE_BIAS_ENABLE)
			wr_high_side_bias_enable = 1'b1;
		else if (reg_addr == `ADDR_LOW_SIDE_BIAS_ENABLE)
			wr_low_side_bias_enable = 1'b1;
		else if (reg_addr == `ADDR_BS_CHARGED)
			wr_bs = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			thr_reg     <= `REG_RESET;
			high_side_bias_enable_reg <= `REG_RESET;
			low_side_bias_enable_reg <= `REG_RESET;
			bs_reg      <= `REG_RESET;
		end else begin
			if (wr_thr)
				thr_reg <= reg_wdata;
			if (wr_high_side_bias_enable)
				high_side_bias_enable_reg <= reg_wdata;
			if (wr_low_side_bias_enable)
				low_side_bias_enable_reg <= reg_wdata;
			if (wr_bs)
				bs_reg <= reg_wdata;
		end
	end

	assign link_dis = bs_reg[`NUM_HS-1:0];

	// per-driver init flags and link registers
	genvar i;
	generate
		for (i = 0; i < `NUM_HS; i++) begin : g_hs
			assign wr_link[i] = wr_ok & (reg_addr == `ADDR_LINK_BASE + `ADDR_W'(i));
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n)
					link_reg[i] <= '0;
				else if (wr_link[i])
					link_reg[i] <= reg_wdata[`NUM_LS-1:0];
			end
			// linked low-side actually driven, not just requested
			assign init_exit[i] = (bs_ready_s[i] & below_s[i])
				| (clamp_s[i] & below_s[i])
				| (|(ls_gate & link_reg[i]))
				| link_dis[i]
				| hs_gate[i];
			assign next_thr[2*i +: 2] = !init_flag[i] ? thr_reg[2*i +: 2] :
				one_volt[i] ? `THR_ONE_VOLT : `THR_HALF_VOLT;
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			init_flag <= '1;
			one_volt  <= '0;
		end else if (!core_rst_n) begin
			init_flag <= '1;
			one_volt  <= '0;
		end else begin
			init_flag <= init_flag & ~(init_exit & {`NUM_HS{init_started}});
			one_volt  <= one_volt | (init_flag & {`NUM_HS{init_expired}});
		end
	end

	assign any_init = |init_flag;

	// the strap only ever forces the internal regulator on
	assign next_vccp_ext = (any_init & strap_dbg) ? 1'b0 : bs_reg[`BS_VCCP_EXT_BIT];

	// high side needs supply above threshold, low side also the delay
	assign next_hs_gate = hs_on_request & {`NUM_HS{core_rst_n & ~uv_s}};
	assign next_ls_gate = ls_on_request & {`NUM_LS{core_rst_n & uv_ok & ~uv_s}};

	// read mux; unmapped addresses read as zero
	always_comb begin
		next_rdata = '0;
		if (reg_addr == `ADDR_SRC_THR_PART2)
			next_rdata = thr_reg;
		else if (reg_addr == `ADDR_HIGH_SIDE_BIAS_ENABLE)
			next_rdata = high_side_bias_enable_reg;
		else if (reg_addr == `ADDR_LOW_SIDE_BIAS_ENABLE)
			next_rdata = low_side_bias_enable_reg;
		else if (reg_addr == `ADDR_BS_CHARGED) begin
			next_rdata = bs_reg;
			next_rdata[`BS_ONE_VOLT_LSB +: `NUM_HS] = one_volt;
		end else begin
			for (int k = 0; k < `NUM_HS; k++)
				if (reg_addr == `ADDR_LINK_BASE + `ADDR_W'(k))
					next_rdata[`NUM_LS-1:0] = link_reg[k];
		end
	end

	// all outputs registered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata                    <= '0;
			combined_reset_n             <= 1'b0;
			serial_enable                <= 1'b0;
			ref_clock_qualified          <= 1'b0;
			init_active                  <= '1;
			bootstrap_low_current_limit  <= '0;
			source_threshold             <= '0;
			one_volt_threshold_indicator <= '0;
			low_side_bias_enable         <= '1;
			high_side_bias_enable        <= '0;
			vccp_external_enable         <= 1'b0;
			hs_gate                      <= '0;
			ls_gate                      <= '0;
			bootstrap_diode_enable       <= 1'b0;
		end else begin
			reg_rdata                    <= next_rdata;
			combined_reset_n             <= core_rst_n;
			serial_enable                <= core_rst_n;
			ref_clock_qualified          <= ref_s & digital_outputs_ready;
			init_active                  <= init_flag;
			bootstrap_low_current_limit  <= init_flag & {`NUM_HS{init_started}};
			source_threshold             <= next_thr;
			one_volt_threshold_indicator <= one_volt;
			low_side_bias_enable         <= any_init ? '1 : low_side_bias_enable_reg[`NUM_LS-1:0];
			high_side_bias_enable        <= high_side_bias_enable_reg[`NUM_HS-1:0] & ~init_flag;
			vccp_external_enable         <= next_vccp_ext;
			hs_gate                      <= next_hs_gate;
			ls_gate                      <= next_ls_gate;
			bootstrap_diode_enable       <= core_rst_n & uv_ok & ~uv_s;
		end
	end

endmodule

// *** core/bootstrap_seq_cfg.svh ***
// constants for the bootstrap init and power-up sequencer
`ifndef BOOTSTRAP_SEQ_CFG_SVH
`define BOOTSTRAP_SEQ_CFG_SVH
`define NUM_HS 7
`define NUM_LS 8
`define CLK_FREQ_MHZ 100
`define DIGIO_READY_TIME_US 100
`define DIGIO_READY_CYCLES (`DIGIO_READY_TIME_US * `CLK_FREQ_MHZ)
`define UV_DELAY_TIME_US 16
`define UV_DELAY_CYCLES (`UV_DELAY_TIME_US * `CLK_FREQ_MHZ)
`define INIT_TIMER_TIME_MS 36
`define INIT_TIMER_CYCLES (`INIT_TIMER_TIME_MS * 1000 * `CLK_FREQ_MHZ)
`define CNT_W 22
`define ADDR_W 9
`define DATA_W 16
`define ADDR_SRC_THR_PART2 9'h16e
`define ADDR_HIGH_SIDE_BIAS_ENABLE 9'h18b
`define ADDR_LOW_SIDE_BIAS_ENABLE 9'h18c
`define ADDR_BS_CHARGED 9'h18d
`define ADDR_LINK_BASE 9'h18f
`define BS_VCCP_EXT_BIT 15
`define BS_ONE_VOLT_LSB 8
`define THR_HALF_VOLT 2'h0
`define THR_ONE_VOLT 2'h1
`define REG_RESET 16'h0000
`endif

// *** core/bootstrap_seq_pkg.sv ***
// shared vector types for the bootstrap init and power-up sequencer
package bootstrap_seq_pkg;
	typedef logic [6:0] hs_vec_t;
	typedef logic [7:0] ls_vec_t;
	typedef logic [13:0] thr_vec_t;
	typedef logic [15:0] reg_word_t;
endpackage

// *** tb/bootstrap_seq_assertions.sv ***
// checker for the bootstrap init and power-up sequencer
`timescale 1ns/1ps
`include "bootstrap_seq_cfg.svh"
module bootstrap_seq_checker #(
	parameter int DIGIO_READY_CYCLES = 20
) (
	// clock, reset and sources
	input wire logic	clock,
	input wire logic	resetn,
	input wire logic	power_on_reset_n,
	input wire logic	external_reset_pin_n,
	input wire logic	predriver_supply_undervoltage,
	// status and overrides
	input wire logic	combined_reset_n,
	input wire logic	serial_enable,
	input wire logic	digital_outputs_ready,
	input wire logic	ref_clock_qualified,
	input wire bootstrap_seq_pkg::hs_vec_t	init_active,
	input wire bootstrap_seq_pkg::hs_vec_t	bootstrap_low_current_limit,
	input wire bootstrap_seq_pkg::hs_vec_t	one_volt_threshold_indicator,
	input wire bootstrap_seq_pkg::ls_vec_t	low_side_bias_enable,
	input wire bootstrap_seq_pkg::hs_vec_t	high_side_bias_enable,
	// gates
	input wire bootstrap_seq_pkg::hs_vec_t	hs_gate,
	input wire bootstrap_seq_pkg::ls_vec_t	ls_gate,
	input wire logic	bootstrap_diode_enable
);
	localparam int UV_DLY = `UV_DELAY_CYCLES;
	int por_cnt;
	int ok_cnt;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// pins lead the design's synchronisers, so these counts are upper bounds
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			por_cnt <= 0;
			ok_cnt <= 0;
		end else begin
			por_cnt <= power_on_reset_n ? por_cnt + 1 : 0;
			ok_cnt <= predriver_supply_undervoltage ? 0 : ok_cnt + 1;
		end
	end
	a_serial_tracks_reset: assert property (serial_enable == combined_reset_n)
		else $error("serial enable differs from core reset");
	a_ext_pin_reset: assert property (!external_reset_pin_n [*5] |-> !combined_reset_n)
		else $error("core reset not asserted by reset pin");
	a_ready_not_early: assert property (digital_outputs_ready |-> por_cnt >= DIGIO_READY_CYCLES)
		else $error("outputs ready too early");
	a_ready_on_time: assert property (por_cnt == DIGIO_READY_CYCLES + 10 |-> digital_outputs_ready)
		else $error("outputs ready too late");
	a_ref_clock_gated: assert property (ref_clock_qualified |->
		digital_outputs_ready || $past(digital_outputs_ready))
		else $error("reference clock passed before ready");
	a_low_side_bias_enable_forced: assert property (|(init_active & $past(init_active)) |->
		low_side_bias_enable == 8'hff)
		else $error("low-side bias not forced in init");
	a_high_side_bias_enable_off: assert property ((init_active & $past(init_active) & high_side_bias_enable) == '0)
		else $error("high-side bias on in init");
	a_limit_in_init: assert property ((bootstrap_low_current_limit &
		~(init_active | $past(init_active))) == '0)
		else $error("low limit outside init");
	a_uv_gates_off: assert property (predriver_supply_undervoltage [*5] |->
		hs_gate == '0 && ls_gate == '0 && !bootstrap_diode_enable)
		else $error("gate on in undervoltage");
	a_ls_wait_delay: assert property (|(ls_gate & ~$past(ls_gate)) |-> ok_cnt >= UV_DLY)
		else $error("low-side on before supply delay");
	a_one_volt_in_init: assert property ((one_volt_threshold_indicator &
		~$past(one_volt_threshold_indicator) & ~$past(init_active) & ~$past(init_active, 2)) == '0)
		else $error("one-volt set outside init");
	c_ls_on: cover property (|ls_gate);
	c_one_volt: cover property (|one_volt_threshold_indicator);
	c_init_done: cover property ($fell(|init_active));
endmodule

bind bootstrap_init_power_up_seq bootstrap_seq_checker #(
	.DIGIO_READY_CYCLES(DIGIO_READY_CYCLES)
) i_checker (
	.clock(clock), .resetn(resetn), .power_on_reset_n(power_on_reset_n),
	.external_reset_pin_n(external_reset_pin_n),
	.predriver_supply_undervoltage(predriver_supply_undervoltage),
	.combined_reset_n(combined_reset_n), .serial_enable(serial_enable),
	.digital_outputs_ready(digital_outputs_ready), .ref_clock_qualified(ref_clock_qualified),
	.init_active(init_active), .bootstrap_low_current_limit(bootstrap_low_current_limit),
	.one_volt_threshold_indicator(one_volt_threshold_indicator),
	.low_side_bias_enable(low_side_bias_enable), .high_side_bias_enable(high_side_bias_enable),
	.hs_gate(hs_gate), .ls_gate(ls_gate), .bootstrap_diode_enable(bootstrap_diode_enable)
);

// *** tb/gate_circuit_model.sv ***
// bootstrap capacitors and source nodes of the external switches
`timescale 1ns/1ps
module gate_circuit_model #(
	parameter int CHARGE_STEP = 30
) (
	// clock and bench control
	input wire logic	clock,
	input wire logic	discharge,
	// from the device
	input wire bootstrap_seq_pkg::hs_vec_t	low_limit,
	input wire bootstrap_seq_pkg::hs_vec_t	hs_gate,
	// comparators back to the device
	output bootstrap_seq_pkg::hs_vec_t	bs_ready,
	output bootstrap_seq_pkg::hs_vec_t	clamp_active,
	output bootstrap_seq_pkg::hs_vec_t	source_below_threshold
);
	int charge [7];
	// cap i is larger with i, so drivers leave init at staggered times
	always @(posedge clock) begin
		for (int i = 0; i < 7; i++) begin
			if (discharge)
				charge[i] <= 0;
			else if (low_limit[i])
				charge[i] <= charge[i] + 1;
			bs_ready[i] <= charge[i] >= CHARGE_STEP * (i + 1);
		end
	end
	assign source_below_threshold = ~hs_gate;
	assign clamp_active = '0;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the bootstrap init and power-up sequencer
`timescale 1ns/1ps
`include "bootstrap_seq_cfg.svh"
module testbench;
	logic clock = 0, resetn = 0, power_on_reset_n = 0, external_reset_pin_n = 0;
	logic serial_port_reset_request_n = 1, debug_strap_pin = 1, ref_clock_pin = 0;
	logic predriver_supply_undervoltage = 1, reg_write = 0, discharge = 0;
	logic [8:0] reg_addr = '0;
	logic combined_reset_n, serial_enable, digital_outputs_ready, ref_clock_qualified;
	logic vccp_external_enable, bootstrap_diode_enable;
	bootstrap_seq_pkg::reg_word_t reg_wdata = '0, reg_rdata, seen;
	bootstrap_seq_pkg::hs_vec_t bs_ready, clamp_active, source_below_threshold, init_active;
	bootstrap_seq_pkg::hs_vec_t hs_on_request = '0, bootstrap_low_current_limit, hs_gate;
	bootstrap_seq_pkg::hs_vec_t one_volt_threshold_indicator, high_side_bias_enable;
	bootstrap_seq_pkg::ls_vec_t ls_on_request = '0, low_side_bias_enable, ls_gate, req;
	bootstrap_seq_pkg::thr_vec_t source_threshold;
	bootstrap_seq_pkg::reg_word_t regm [int];
	int err_total = 0, n_checks = 0, k;
	int addrs [$] = '{'h16e, 'h18b, 'h18c, 'h18d, 'h18f, 'h190, 'h191, 'h192, 'h193,
		'h194, 'h195, 'h100};

	bootstrap_init_power_up_seq #(.DIGIO_READY_CYCLES(20), .INIT_TIMER_CYCLES(50)) i_dut (
		.clock(clock), .resetn(resetn), .power_on_reset_n(power_on_reset_n),
		.external_reset_pin_n(external_reset_pin_n), .debug_strap_pin(debug_strap_pin),
		.serial_port_reset_request_n(serial_port_reset_request_n), .ref_clock_pin(ref_clock_pin),
		.predriver_supply_undervoltage(predriver_supply_undervoltage), .bs_ready(bs_ready),
		.clamp_active(clamp_active), .source_below_threshold(source_below_threshold),
		.hs_on_request(hs_on_request), .ls_on_request(ls_on_request), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.combined_reset_n(combined_reset_n), .serial_enable(serial_enable),
		.digital_outputs_ready(digital_outputs_ready), .ref_clock_qualified(ref_clock_qualified),
		.init_active(init_active), .bootstrap_low_current_limit(bootstrap_low_current_limit),
		.source_threshold(source_threshold), .low_side_bias_enable(low_side_bias_enable),
		.one_volt_threshold_indicator(one_volt_threshold_indicator), .hs_gate(hs_gate),
		.high_side_bias_enable(high_side_bias_enable), .ls_gate(ls_gate),
		.vccp_external_enable(vccp_external_enable), .bootstrap_diode_enable(bootstrap_diode_enable)
	);
	gate_circuit_model i_gates (
		.clock(clock), .discharge(discharge), .low_limit(bootstrap_low_current_limit),
		.hs_gate(hs_gate), .bs_ready(bs_ready), .clamp_active(clamp_active),
		.source_below_threshold(source_below_threshold)
	);

	initial forever #5 clock = ~clock;
	always @(negedge clock) ref_clock_pin <= 1'($urandom);

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// only the documented fields are compared; spare bits are left open
	function automatic logic [15:0] fmask(input int a);
		return a == 'h16e ? 16'h3fff : a == 'h18b ? 16'h007f : a == 'h18d ? 16'h807f :
			a == 'h100 ? 16'hffff : 16'h00ff;
	endfunction
	task automatic wr(input int a, input logic [15:0] d);
		reg_write = 1;
		reg_addr = a[8:0];
		reg_wdata = d & fmask(a);
		cyc(1);
		reg_write = 0;
		if (serial_port_reset_request_n && regm.exists(a))
			regm[a] = d & fmask(a);
		// one idle edge so a following write never re-raises the strobe in this step
		cyc(1);
	endtask
	task automatic rd(input int a);
		reg_addr = a[8:0];
		cyc(2);
		seen = reg_rdata;
		chk(seen & fmask(a), regm.exists(a) ? regm[a] : 16'h0000);
	endtask

	initial begin
		k = $urandom(38);
		foreach (addrs[i]) if (addrs[i] != 'h100) regm[addrs[i]] = '0;
		cyc(3);
		resetn = 1;
		cyc(8);
		power_on_reset_n = 1;
		external_reset_pin_n = 1;
		cyc(3);
		chk(digital_outputs_ready, 0);
		chk(ref_clock_qualified, 0);
		chk(init_active, 7'h7f);
		chk(low_side_bias_enable, 8'hff);
		cyc(30);
		chk(digital_outputs_ready, 1);
		chk(serial_enable, 1);
		cyc(10000);
		$display("reset test done");
		foreach (addrs[i]) rd(addrs[i]);
		foreach (addrs[i]) wr(addrs[i], addrs[i] == 'h18d ? 16'h8000 :
			addrs[i] == 'h18b ? 16'h0000 : 16'($urandom));
		foreach (addrs[i]) rd(addrs[i]);
		$display("register test done");
		chk(vccp_external_enable, 0);
		chk(high_side_bias_enable, 0);
		chk(bootstrap_low_current_limit, 0);
		predriver_supply_undervoltage = 0;
		cyc(10);
		chk(bootstrap_low_current_limit, 7'h7f);
		chk(source_threshold, 0);
		cyc(70);
		chk(one_volt_threshold_indicator, 7'h7e);
		chk(source_threshold[13:12], `THR_ONE_VOLT);
		cyc(200);
		chk(init_active, 0);
		chk(bootstrap_low_current_limit, 0);
		chk(low_side_bias_enable, regm['h18c]);
		chk(source_threshold, regm['h16e]);
		chk(vccp_external_enable, 1);
		wr('h18b, 16'($urandom));
		cyc(3);
		chk(high_side_bias_enable, regm['h18b]);
		rd('h18d);
		chk(seen[14:8], 7'h7e);
		$display("init test done");
		req = 8'($urandom) | 8'h01;
		ls_on_request = req;
		cyc(1200);
		chk(ls_gate, 0);
		cyc(200);
		chk(ls_gate, req);
		repeat (2) begin
			predriver_supply_undervoltage = 1;
			hs_on_request = 7'h40;
			cyc(6);
			chk(ls_gate, 0);
			chk(hs_gate, 0);
			chk(bootstrap_diode_enable, 0);
			predriver_supply_undervoltage = 0;
			hs_on_request = 0;
			cyc(1500);
			chk(ls_gate, 0);
			cyc(150);
			chk(ls_gate, req);
		end
		$display("supply test done");
		for (k = 0; k < 7; k++) wr('h18f + k, k == 3 ? 16'h0001 : 16'h0000);
		serial_port_reset_request_n = 0;
		discharge = 1;
		cyc(5);
		chk(combined_reset_n, 0);
		chk(serial_enable, 0);
		chk(init_active, 7'h7f);
		wr('h18d, 16'h807f);
		serial_port_reset_request_n = 1;
		discharge = 0;
		cyc(6);
		wr('h18d, 16'h8004);
		hs_on_request = 7'h02;
		cyc(6);
		chk(init_active, 7'h71);
		rd('h18d);
		$display("exit test done");
		final_report();
	end
	initial begin
		cyc(40000);
		err_total++;
		final_report();
	end
endmodule
